// file: hw/serial_pkg.sv
package serial_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [11:0] ADDR_DATA = 12'h000;
    localparam logic [11:0] ADDR_CTRL_ONE = 12'h004;
    localparam logic [11:0] ADDR_CTRL_TWO = 12'h008;
    localparam logic [11:0] ADDR_FLAG = 12'h00c;
    localparam logic [11:0] ADDR_BAUD = 12'h010;
    localparam logic [11:0] ADDR_PORT = 12'h014;

    // serial_ctrl_one fields.
    localparam int C1_RX_NINTH = 7;
    localparam int C1_TX_NINTH = 6;
    localparam int C1_NINE_BIT = 4;
    localparam int C1_ROUSE = 3;

    // serial_ctrl_two fields.
    localparam int C2_TX_BUF_IRQ = 7;
    localparam int C2_TX_DONE_IRQ = 6;
    localparam int C2_RX_IRQ = 5;
    localparam int C2_QUIET_IRQ = 4;
    localparam int C2_TX_ON = 3;
    localparam int C2_RX_ON = 2;
    localparam int C2_SLEEP = 1;
    localparam int C2_BREAK = 0;

    // serial_flag_reg fields.
    localparam int FL_TX_EMPTY = 7;
    localparam int FL_TX_SENT = 6;
    localparam int FL_RX_FULL = 5;
    localparam int FL_QUIET = 4;
    localparam int FL_LOST = 3;
    localparam int FL_NOISY = 2;
    localparam int FL_BAD_STOP = 1;

    // Port control fields.
    localparam int PT_DIR_LO = 0;
    localparam int PT_LATCH_LO = 4;
    localparam int PT_WIRED_OR = 8;

    // Reset values.
    localparam logic [15:0] BAUD_RESET = 16'h0000;
    localparam logic [1:0] DIR_RESET = 2'h0;
    localparam logic [1:0] LATCH_RESET = 2'h0;

    // Bit timing of the transmitter and the recovery stage.
    localparam logic [3:0] PHASE_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_ONE = 4'h7;
    localparam logic [3:0] SAMPLE_TWO = 4'h8;
    localparam logic [3:0] SAMPLE_THREE = 4'h9;
    localparam logic [3:0] RESYNC_LATE = 4'hc;
    localparam logic [3:0] RESYNC_EARLY = 4'h3;

    // Frame lengths in bit times, start and stop included.
    localparam logic [3:0] FRAME_SHORT = 4'ha;
    localparam logic [3:0] FRAME_LONG = 4'hb;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_BITS = 2'b01
    } rx_state_e;

endpackage : serial_pkg

// file: hw/async_serial_transceiver.sv
// Notes on behaviour
// - Data loaded into the shifter gets start zero at bit 0 and stop one.
// - Each zero-to-one change of tx_on queues an all-ones preamble frame.
// - send_break_bit loads all-zero frames, stop position included.
// - tx_ninth_bit is sent as ninth data bit only in nine-bit format.
// - Preamble and break frames are one bit longer in nine-bit format.
// - Hardware sets buffer-empty and all-sent flags; software reads them.
// - Interrupt on buffer empty or all sent when their enables are set.
// - Line sampled at sixteen times bit rate; shifter advances once a bit.
// - Recovery passes the decided bit on and flags disagreeing samples.
// - Receiver runs only with rx_on; frame is 10 or 11 bits.
// - After the stop bit the character goes to the holding buffer.
// - A character arriving while the buffer is unread sets the lost flag.
// - rx_rouse_select picks address-mark or idle-line wake-up.
// - Software sets rx_sleep_bit; the wake-up condition clears it.
// - Interrupt on full, lost or quiet line when their enables are set.
// - Flag register shows quiet line, noise and bad stop bit too.
// - When enabled, receive pin is input and transmit pin is output.
// - Wired-OR control still turns off high drive on serial pins.
// - Data port reads the receive buffer and writes the transmit buffer.
// - Three mid-bit samples decide the bit by majority.
// - Receive timing resynchronises on a falling edge of the line only near a bit boundary, phase 12 through 3.
// - Frames are one start, eight or nine data and one stop bit.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module async_serial_transceiver
    import serial_pkg::*;
(
    // Clock and reset.
    input logic pclk,
    input logic presetn,
    // APB slave.
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins.
    input logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_oe,
    output logic rx_pin_out,
    output logic rx_pin_oe,
    // Interrupt request.
    output logic serial_irq
);

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [15:0] baud_div;
        logic [15:0] baud_cnt;
        logic nine_bit;
        logic rouse_mark;
        logic tx_ninth;
        logic rx_ninth;
        logic tx_buf_irq_en;
        logic tx_done_irq_en;
        logic rx_irq_en;
        logic quiet_irq_en;
        logic tx_on;
        logic rx_on;
        logic sleep;
        logic send_break;
        logic [1:0] dir;
        logic [1:0] latch;
        logic wired_or;
        logic [7:0] tx_buf;
        logic tx_full;
        logic tx_sent;
        logic preamble_pend;
        logic [10:0] tx_sh;
        logic [3:0] tx_left;
        logic [3:0] tx_sub;
        logic rx_s1;
        logic rx_s2;
        logic rx_s3;
        rx_state_e rx_state;
        logic [3:0] phase;
        logic [3:0] rx_idx;
        logic [1:0] votes;
        logic cur_noise;
        logic [8:0] rx_sh;
        logic [7:0] rx_hold;
        logic rx_full;
        logic rx_lost;
        logic rx_noisy;
        logic rx_bad_stop;
        logic quiet;
        logic quiet_armed;
        logic [7:0] idle_cnt;
        logic txd;
        logic txd_oe;
        logic rxd;
        logic rxd_oe;
        logic irq;
    } state_s;

    state_s s;
    state_s n;
    logic tick16;
    logic tx_bit;

    function automatic logic maj3(input logic a, input logic b, input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction : maj3

    function automatic logic [3:0] frame_len(input logic nine);
        return nine ? FRAME_LONG : FRAME_SHORT;
    endfunction : frame_len

    always_comb begin
        logic setup;
        logic wr;
        logic rd;
        logic bit_val;
        logic [3:0] nbits;
        logic data_wr;
        n = s;
        setup = psel & penable & ~s.pready;
        wr = psel & penable & s.pready & pwrite;
        rd = psel & penable & s.pready & ~pwrite;
        nbits = frame_len(s.nine_bit);
        data_wr = wr & (paddr == ADDR_DATA);
        bit_val = 1'b0;

        // Bus answers one cycle after the access phase starts.
        n.pready = setup;
        n.pslverr = 1'b0;
        if (setup) begin
            n.prdata = 32'h0000_0000;
            unique case (paddr)
                ADDR_DATA: n.prdata[7:0] = s.rx_hold;
                ADDR_CTRL_ONE: begin
                    n.prdata[C1_RX_NINTH] = s.rx_ninth;
                    n.prdata[C1_TX_NINTH] = s.tx_ninth;
                    n.prdata[C1_NINE_BIT] = s.nine_bit;
                    n.prdata[C1_ROUSE] = s.rouse_mark;
                end
                ADDR_CTRL_TWO: n.prdata[7:0] = {s.tx_buf_irq_en,
                    s.tx_done_irq_en, s.rx_irq_en, s.quiet_irq_en,
                    s.tx_on, s.rx_on, s.sleep, s.send_break};
                ADDR_FLAG: begin
                    n.prdata[FL_TX_EMPTY] = ~s.tx_full;
                    n.prdata[FL_TX_SENT] = s.tx_sent;
                    n.prdata[FL_RX_FULL] = s.rx_full;
                    n.prdata[FL_QUIET] = s.quiet;
                    n.prdata[FL_LOST] = s.rx_lost;
                    n.prdata[FL_NOISY] = s.rx_noisy;
                    n.prdata[FL_BAD_STOP] = s.rx_bad_stop;
                end
                ADDR_BAUD: n.prdata[15:0] = s.baud_div;
                ADDR_PORT: begin
                    n.prdata[PT_DIR_LO+1:PT_DIR_LO] = s.dir;
                    n.prdata[PT_LATCH_LO+1:PT_LATCH_LO] = s.latch;
                    n.prdata[PT_WIRED_OR] = s.wired_or;
                end
                default: n.pslverr = 1'b1;
            endcase
        end

        // Software side effects, taken at the completing edge.
        if (wr) begin
            unique case (paddr)
                ADDR_DATA: begin
                    n.tx_buf = pwdata[7:0];
                    n.tx_full = 1'b1;
                    n.tx_sent = 1'b0;
                end
                ADDR_CTRL_ONE: begin
                    n.tx_ninth = pwdata[C1_TX_NINTH];
                    n.nine_bit = pwdata[C1_NINE_BIT];
                    n.rouse_mark = pwdata[C1_ROUSE];
                end
                ADDR_CTRL_TWO: begin
                    n.tx_buf_irq_en = pwdata[C2_TX_BUF_IRQ];
                    n.tx_done_irq_en = pwdata[C2_TX_DONE_IRQ];
                    n.rx_irq_en = pwdata[C2_RX_IRQ];
                    n.quiet_irq_en = pwdata[C2_QUIET_IRQ];
                    n.tx_on = pwdata[C2_TX_ON];
                    n.rx_on = pwdata[C2_RX_ON];
                    n.sleep = pwdata[C2_SLEEP];
                    n.send_break = pwdata[C2_BREAK];
                    if (pwdata[C2_TX_ON] & ~s.tx_on) begin
                        n.preamble_pend = 1'b1;
                        n.tx_sent = 1'b0;
                    end
                end
                ADDR_BAUD: n.baud_div = pwdata[15:0];
                ADDR_PORT: begin
                    n.dir = pwdata[PT_DIR_LO+1:PT_DIR_LO];
                    n.latch = pwdata[PT_LATCH_LO+1:PT_LATCH_LO];
                    n.wired_or = pwdata[PT_WIRED_OR];
                end
                default: ;
            endcase
        end
        if (rd & (paddr == ADDR_DATA)) begin
            n.rx_full = 1'b0;
            n.rx_lost = 1'b0;
            n.rx_noisy = 1'b0;
            n.rx_bad_stop = 1'b0;
            n.quiet = 1'b0;
        end

        // Oversampling tick at sixteen times the bit rate.
        tick16 = (s.baud_cnt == 16'h0000);
        n.baud_cnt = tick16 ? s.baud_div : s.baud_cnt - 16'h0001;
        tx_bit = tick16 & (s.tx_sub == PHASE_LAST);
        if (tick16) begin
            n.tx_sub = s.tx_sub + 4'h1;
        end

        // Transmitter: one shift per bit time.
        if (tx_bit) begin
            if (s.tx_left > 4'h1) begin
                n.tx_sh = {1'b1, s.tx_sh[10:1]};
                n.tx_left = s.tx_left - 4'h1;
            end else if (s.tx_on & s.send_break) begin
                n.tx_sh = 11'h000;
                n.tx_left = nbits;
            end else if (s.tx_on & s.preamble_pend) begin
                n.tx_sh = 11'h7ff;
                n.tx_left = nbits;
                n.preamble_pend = 1'b0;
            end else if (s.tx_on & s.tx_full) begin
                // Stop at the top, ninth bit only in long format.
                n.tx_sh = {1'b1, s.nine_bit ? s.tx_ninth : 1'b1,
                    s.tx_buf, 1'b0};
                n.tx_left = nbits;
                n.tx_full = data_wr;
            end else begin
                n.tx_left = 4'h0;
                if (s.tx_left == 4'h1) begin
                    n.tx_sent = 1'b1;
                end
            end
        end

        // Receive pin synchroniser and recovery stage.
        n.rx_s1 = serial_in_pin;
        n.rx_s2 = s.rx_s1;
        n.rx_s3 = s.rx_s2;
        if (~s.rx_s2) begin
            n.idle_cnt = 8'h00;
        end
        if (~s.rx_on) begin
            n.rx_state = RX_IDLE;
            n.idle_cnt = 8'h00;
        end else begin
            unique case (s.rx_state)
                RX_IDLE: begin
                    if (s.rx_s3 & ~s.rx_s2) begin
                        n.rx_state = RX_BITS;
                        n.phase = 4'h0;
                        n.rx_idx = 4'h0;
                        n.cur_noise = 1'b0;
                    end else if (tick16 & s.rx_s2 &
                                 (s.idle_cnt != {nbits, 4'h0})) begin
                        n.idle_cnt = s.idle_cnt + 8'h01;
                        if (s.idle_cnt + 8'h01 == {nbits, 4'h0}) begin
                            if (s.sleep & ~s.rouse_mark) begin
                                n.sleep = 1'b0;
                            end else if (s.quiet_armed & ~s.sleep) begin
                                n.quiet = 1'b1;
                                n.quiet_armed = 1'b0;
                            end
                        end
                    end
                end
                RX_BITS: begin
                    if (s.rx_s3 & ~s.rx_s2 &
                        (s.phase >= RESYNC_LATE |
                         s.phase <= RESYNC_EARLY)) begin
                        n.phase = 4'h0;
                    end else if (tick16) begin
                        n.phase = s.phase + 4'h1;
                        if (s.phase == SAMPLE_ONE) begin
                            n.votes[1] = s.rx_s2;
                        end
                        if (s.phase == SAMPLE_TWO) begin
                            n.votes[0] = s.rx_s2;
                        end
                        if (s.phase == SAMPLE_THREE) begin
                            bit_val = maj3(s.votes[1], s.votes[0],
                                s.rx_s2);
                            n.cur_noise = s.cur_noise |
                                ~((s.votes[1] == s.votes[0]) &
                                  (s.votes[0] == s.rx_s2));
                            n.rx_idx = s.rx_idx + 4'h1;
                            if (s.rx_idx == 4'h0) begin
                                if (bit_val) begin
                                    n.rx_state = RX_IDLE;
                                end
                            end else if (s.rx_idx != nbits - 4'h1) begin
                                n.rx_sh = {bit_val, s.rx_sh[8:1]};
                            end else begin
                                n.rx_state = RX_IDLE;
                                n.idle_cnt = 8'h00;
                                if (s.sleep & s.rouse_mark & s.rx_sh[8]) begin
                                    n.sleep = 1'b0;
                                end
                                if (~s.sleep |
                                    (s.rouse_mark & s.rx_sh[8])) begin
                                    n.quiet_armed = 1'b1;
                                    if (s.rx_full) begin
                                        n.rx_lost = 1'b1;
                                    end else begin
                                        n.rx_hold = s.nine_bit ?
                                            s.rx_sh[7:0] : s.rx_sh[8:1];
                                        n.rx_ninth = s.nine_bit & s.rx_sh[8];
                                        n.rx_full = 1'b1;
                                        n.rx_noisy = n.cur_noise;
                                        n.rx_bad_stop = ~bit_val;
                                    end
                                end
                            end
                        end
                    end
                end
                default: n.rx_state = RX_IDLE;
            endcase
        end

        // Pin drivers; serial logic takes the pins over while enabled.
        n.txd = (n.tx_on | (n.tx_left != 4'h0)) ?
            ((n.tx_left != 4'h0) ? n.tx_sh[0] : 1'b1) : n.latch[1];
        n.txd_oe = (n.tx_on | (n.tx_left != 4'h0) | n.dir[1]) &
            ~(n.wired_or & n.txd);
        n.rxd = n.latch[0];
        n.rxd_oe = ~n.rx_on & n.dir[0] &
            ~(n.wired_or & n.latch[0]);

        n.irq = (n.tx_buf_irq_en & ~n.tx_full) |
            (n.tx_done_irq_en & n.tx_sent) |
            (n.rx_irq_en & (n.rx_full | n.rx_lost)) |
            (n.quiet_irq_en & n.quiet);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.baud_div <= BAUD_RESET;
            s.baud_cnt <= BAUD_RESET;
            s.dir <= DIR_RESET;
            s.latch <= LATCH_RESET;
            s.tx_sent <= 1'b1;
            s.rx_s1 <= 1'b1;
            s.rx_s2 <= 1'b1;
            s.rx_s3 <= 1'b1;
            s.rx_state <= RX_IDLE;
            s.txd <= 1'b0;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign serial_out_pin = s.txd;
    assign serial_out_oe = s.txd_oe;
    assign rx_pin_out = s.rxd;
    assign rx_pin_oe = s.rxd_oe;
    assign serial_irq = s.irq;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_data_frame_load: assert property ($fell(s.tx_full) |->
        s.tx_sh[0] == 1'b0 && s.tx_sh[10] == 1'b1)
        else $error("data frame lacks start or stop bit");
    a_preamble_ones: assert property ($fell(s.preamble_pend) |->
        s.tx_sh == 11'h7ff && s.tx_left != 4'h0)
        else $error("preamble frame not all ones");
    a_break_zeros: assert property (tx_bit && s.tx_left <= 4'h1 &&
        s.tx_on && s.send_break |=> s.tx_sh == 11'h000)
        else $error("break frame not all zeros");
    a_frame_length: assert property (tx_bit && s.tx_left <= 4'h1 |=>
        s.tx_left == 4'h0 || s.tx_left == frame_len($past(s.nine_bit)))
        else $error("frame length wrong");
    a_idle_high: assert property (s.tx_on && s.tx_left == 4'h0 |->
        s.txd == 1'b1)
        else $error("transmit line not idle high");
    a_pin_takeover: assert property (s.tx_on |->
        s.txd_oe || (s.wired_or && s.txd))
        else $error("transmit pin not driven");
    a_rx_pin_input: assert property (s.rx_on |-> !s.rxd_oe)
        else $error("receive pin driven while enabled");
    a_rx_off_idle: assert property (!s.rx_on |=>
        s.rx_state == RX_IDLE) else $error("receiver active while disabled");
    a_lost_keeps_buf: assert property ($rose(s.rx_lost) |->
        $stable(s.rx_hold) && s.rx_full)
        else $error("holding buffer overwritten on overrun");
    a_irq_sources: assert property (
        (s.tx_buf_irq_en && !s.tx_full) ||
        (s.rx_irq_en && s.rx_full) |-> serial_irq)
        else $error("interrupt not raised");
    a_bus_answer: assert property (psel && penable && !pready |=>
        pready ##1 !pready) else $error("bus answer timing wrong");

endmodule : async_serial_transceiver

// file: verification/far_uart.sv
`timescale 1ns/100ps
module far_uart (
    // Clock.
    input wire logic pclk,
    // Line from the block and format choice.
    input wire logic tx_line,
    input wire logic nine,
    // Line into the block.
    output logic rx_line
);
    localparam int BIT_CYC = 16;
    logic [8:0] got;
    logic got_stop;
    int got_cnt;

    initial begin
        rx_line = 1'b1;
        got_cnt = 0;
    end

    // Start zero, data least significant first, stop one.
    task automatic send(input logic [8:0] v);
        rx_line <= 1'b0;
        repeat (BIT_CYC) @(posedge pclk);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            rx_line <= v[i];
            repeat (BIT_CYC) @(posedge pclk);
        end
        rx_line <= 1'b1;
        repeat (BIT_CYC) @(posedge pclk);
    endtask : send

    // Samples each bit of an incoming frame in its middle.
    always begin
        @(negedge tx_line);
        repeat (BIT_CYC / 2) @(posedge pclk);
        if (tx_line === 1'b0) begin
            got = 9'h000;
            for (int i = 0; i < (nine ? 9 : 8); i++) begin
                repeat (BIT_CYC) @(posedge pclk);
                got[i] = tx_line;
            end
            repeat (BIT_CYC) @(posedge pclk);
            got_stop = tx_line;
            got_cnt++;
        end
    end
endmodule : far_uart

// file: verification/async_serial_transceiver_tb.sv
`timescale 1ns/100ps
module async_serial_transceiver_tb;
    import serial_pkg::*;
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin \
    err_total++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
    logic pclk, presetn, psel, penable, pwrite, e, nine;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, serial_in_pin, serial_out_pin, serial_out_oe;
    logic rx_pin_out, rx_pin_oe, serial_irq;
    wire tx_wire;
    int err_total, comparisons, n;

    // The transmit line has a pull-up when the pin is not driven.
    assign tx_wire = serial_out_oe ? serial_out_pin : 1'b1;

    async_serial_transceiver u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
        .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe),
        .serial_irq(serial_irq));
    far_uart u_far (.pclk(pclk), .tx_line(tx_wire), .nine(nine),
        .rx_line(serial_in_pin));

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        q = prdata;
        e = pslverr;
        if (t >= 50) err_total++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wait_got(input int k);
        n = 0;
        while (u_far.got_cnt < k && n < 2000) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_got

    task automatic results;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    task automatic t_reset;
        apb(1'b0, ADDR_FLAG, 32'h0);
        `CHK("flag", 32'h000000c0, q)
        apb(1'b0, 12'hffc, 32'h0);
        `CHK("unmapped", 1'b1, e)
        apb(1'b1, ADDR_CTRL_TWO, 32'h80);
        `CHK("irq tx empty", 1'b1, serial_irq)
        apb(1'b1, ADDR_CTRL_TWO, 32'h0);
        `CHK("irq off", 1'b0, serial_irq)
        $display("reset test done");
    endtask : t_reset

    task automatic t_tx;
        apb(1'b1, ADDR_CTRL_TWO, 32'h08);
        apb(1'b1, ADDR_DATA, 32'ha5);
        wait_got(1);
        `CHK("preamble delay", 1'b1, n > 290)
        `CHK("tx byte", 9'h0a5, u_far.got)
        `CHK("tx stop", 1'b1, u_far.got_stop)
        `CHK("tx oe", 1'b1, serial_out_oe)
        repeat (40) @(posedge pclk);
        apb(1'b0, ADDR_FLAG, 32'h0);
        `CHK("all sent", 32'h000000c0, q)
        $display("tx test done");
    endtask : t_tx

    task automatic t_nine;
        nine = 1'b1;
        apb(1'b1, ADDR_CTRL_ONE, 32'h50);
        apb(1'b1, ADDR_DATA, 32'h5a);
        wait_got(2);
        `CHK("ninth bit", 9'h15a, u_far.got)
        repeat (40) @(posedge pclk);
        apb(1'b1, ADDR_CTRL_ONE, 32'h0);
        nine = 1'b0;
        $display("nine test done");
    endtask : t_nine

    task automatic t_break;
        apb(1'b1, ADDR_CTRL_TWO, 32'h09);
        wait_got(3);
        `CHK("break data", 9'h000, u_far.got)
        `CHK("break stop", 1'b0, u_far.got_stop)
        apb(1'b1, ADDR_CTRL_TWO, 32'h08);
        repeat (400) @(posedge pclk);
        `CHK("idle line", 1'b1, tx_wire)
        $display("break test done");
    endtask : t_break

    task automatic t_rx;
        apb(1'b1, ADDR_CTRL_TWO, 32'h2c);
        u_far.send(9'h03c);
        repeat (4) @(posedge pclk);
        apb(1'b0, ADDR_FLAG, 32'h0);
        `CHK("rx full", 32'h20, q & 32'h3e)
        `CHK("rx irq", 1'b1, serial_irq)
        `CHK("rx pin oe", 1'b0, rx_pin_oe)
        u_far.send(9'h0c3);
        repeat (4) @(posedge pclk);
        apb(1'b0, ADDR_FLAG, 32'h0);
        `CHK("overrun", 32'h28, q & 32'h3e)
        apb(1'b0, ADDR_DATA, 32'h0);
        `CHK("rx data", 32'h3c, q)
        apb(1'b0, ADDR_FLAG, 32'h0);
        `CHK("flags clear", 32'h0, q & 32'h3e)
        $display("rx test done");
    endtask : t_rx

    task automatic t_wake;
        apb(1'b1, ADDR_CTRL_ONE, 32'h08);
        apb(1'b1, ADDR_CTRL_TWO, 32'h2e);
        u_far.send(9'h03c);
        repeat (4) @(posedge pclk);
        apb(1'b0, ADDR_FLAG, 32'h0);
        `CHK("asleep", 32'h0, q & 32'h3e)
        u_far.send(9'h081);
        repeat (200) @(posedge pclk);
        apb(1'b0, ADDR_CTRL_TWO, 32'h0);
        `CHK("woken", 32'h2c, q)
        apb(1'b0, ADDR_FLAG, 32'h0);
        `CHK("quiet", 32'h30, q & 32'h3e)
        apb(1'b0, ADDR_DATA, 32'h0);
        `CHK("wake data", 32'h81, q)
        apb(1'b1, ADDR_CTRL_ONE, 32'h0);
        $display("wake test done");
    endtask : t_wake

    task automatic t_wired;
        apb(1'b1, ADDR_PORT, 32'h110);
        repeat (3) @(posedge pclk);
        `CHK("wired oe", 1'b0, serial_out_oe)
        `CHK("rx latch", 1'b1, rx_pin_out)
        apb(1'b1, ADDR_PORT, 32'h0);
        $display("wired test done");
    endtask : t_wired

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial begin
        repeat (60000) @(posedge pclk);
        err_total++;
        results();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        nine = 1'b0;
        err_total = 0;
        comparisons = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_tx();
        t_nine();
        t_break();
        t_rx();
        t_wake();
        t_wired();
        results();
    end
endmodule : async_serial_transceiver_tb
